// ---- inc/apfc_defs.vh ----
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef APFC_DEFS_VH
`define APFC_DEFS_VH
`define APFC_ADDR_MODE 3'h0
`define APFC_ADDR_CHAN 3'h1
`define APFC_ADDR_PFMODE 3'h2
`define APFC_ADDR_THRESH 3'h3
`define APFC_ADDR_RESULT 3'h4
`define APFC_ADDR_IRQSTAT 3'h5
`define APFC_ADDR_IRQMASK 3'h6
`define APFC_ADDR_STATUS 3'h7
`define APFC_MODE_RUN 7
`define APFC_MODE_FR_HI 5
`define APFC_MODE_FR_LO 3
`define APFC_MODE_CPWR 0
`define APFC_PF_EN 7
`define APFC_PF_SENSE 6
`define APFC_MODE_RST 8'h00
`define APFC_CHAN_RST 8'h00
`define APFC_PFM_RST 8'h00
`define APFC_PFT_RST 8'h00
`define APFC_MASK_RST 8'h00
`define APFC_IRQ_END 0
`define APFC_IRQ_RESTART 1
`define APFC_CYC_288 9'd288
`define APFC_CYC_240 9'd240
`define APFC_CYC_192 9'd192
`define APFC_CYC_144 9'd144
`define APFC_CYC_120 9'd120
`define APFC_CYC_96 9'd96
`define APFC_START_DELAY 9'd32
`define APFC_SAR_BITS 10
`endif

// ---- rtl/apfc_adc_control.v ----
// Control logic of a 10-bit successive-approximation converter with power-fail compare
// Notes on behaviour
// - Power-fail mode: compare result upper byte with threshold; interrupt only on match.
// - Channel comes from channel-select bits 1:0; rewriting them switches channel.
// - After a channel change next compare comes one selected conversion time later.
// - Result read meeting result write: read first, new result written afterwards.
// - Mode/channel write meeting conversion end: write wins, no result, no interrupt.
// - Channel-select write does not clear the conversion-end flag.
// - Mode/channel write may spoil result; software reads result first.
// - Converter stops in standby; clear run bit also cuts resistor string current.
// - Sample switch closed for one sixth of conversion time, then open.
// - Sense 0: fire when byte >= threshold; sense 1: fire when byte < threshold.
// - Conversions repeat while run; any control register write restarts conversion.
// - Run bit 7, power bit 0 of mode; enable bit 7, sense bit 6 of power-fail mode.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "apfc_defs.vh"
module apfc_adc_control (
  input wire core_clk,
  input wire rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdata,
  input wire standbyReq,
  input wire compareHigh,
  output reg [1:0] channelSel,
  output reg sampleClose,
  output reg comparatorPower,
  output reg refStringOn,
  output reg [9:0] sarTrial,
  output reg conversionBusy,
  output reg conversionEndIrq,
  output reg irqOut
);
  localparam ST_IDLE = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_CONV = 2'd2;

  reg [7:0] modeReg;
  reg [7:0] chanReg;
  reg [7:0] pfModeReg;
  reg [7:0] threshReg;
  reg [15:0] resultReg;
  reg [7:0] irqStatReg;
  reg [7:0] irqMaskReg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [8:0] cnt_reg;
  reg [8:0] cnt_next;
  reg [9:0] sar_reg;
  reg [3:0] bitIdx_reg;
  reg firstAfterChan_reg;
  reg pendValid_reg;
  reg [15:0] pendResult_reg;
  reg pendIrq_reg;

  wire running = modeReg[`APFC_MODE_RUN] & ~standbyReq;
  wire wrMode = regWr & (regAddr == `APFC_ADDR_MODE);
  wire wrChan = regWr & (regAddr == `APFC_ADDR_CHAN);
  wire ctrlWr = regWr & (regAddr <= `APFC_ADDR_THRESH);
  wire rdResult = regRd & (regAddr == `APFC_ADDR_RESULT);

  ////////////////////////////////////////////////////////////////
  reg [8:0] convCycles;
  always @* begin
    case (modeReg[`APFC_MODE_FR_HI:`APFC_MODE_FR_LO])
      3'h0: convCycles = `APFC_CYC_288;
      3'h1: convCycles = `APFC_CYC_240;
      3'h2: convCycles = `APFC_CYC_192;
      3'h4: convCycles = `APFC_CYC_144;
      3'h5: convCycles = `APFC_CYC_120;
      3'h6: convCycles = `APFC_CYC_96;
      default: convCycles = `APFC_CYC_288;
    endcase
  end
  // Sample window: one sixth; conversion bits spread over the remainder
  wire [8:0] sampleCycles = convCycles / 9'd6;
  wire [8:0] bitSlot = (convCycles - sampleCycles) / 9'd10;
  wire [8:0] convEnd = sampleCycles + bitSlot * 9'd10;

  ////////////////////////////////////////////////////////////////
  wire [9:0] sarDone;
  wire [9:0] curBit = 10'h200 >> bitIdx_reg;
  assign sarDone = compareHigh ? sar_reg : (sar_reg & ~curBit);
  wire bitTick = (state_reg == ST_CONV) && (cnt_reg >= sampleCycles) && (bitIdx_reg < 4'd10)
    && ((cnt_reg - sampleCycles) == bitSlot * {5'h0, bitIdx_reg} + bitSlot - 9'd1);
  wire convDone = (state_reg == ST_CONV) && (cnt_reg == convEnd - 9'd1);
  wire [9:0] finalSar = (bitIdx_reg == 4'd9 && bitTick) ? sarDone : sar_reg;
  wire [15:0] newResult = {finalSar, 6'h00};
  // Power-fail gating of the end interrupt
  wire upperGe = newResult[15:8] >= threshReg;
  wire pfMatch = pfModeReg[`APFC_PF_SENSE] ? ~upperGe : upperGe;
  wire endIrq = ~pfModeReg[`APFC_PF_EN] | pfMatch;

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg + 9'd1;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = 9'd0;
        if (running) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cnt_reg == `APFC_START_DELAY - 9'd1) begin
          state_next = ST_CONV;
          cnt_next = 9'd0;
        end
      end
      ST_CONV: begin
        if (convDone) begin
          cnt_next = 9'd0;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next = 9'd0;
      end
    endcase
    if (!running) begin
      state_next = ST_IDLE;
      cnt_next = 9'd0;
    end else if (ctrlWr) begin
      // Channel change skips the start delay so the next end lands one conversion time later
      state_next = wrChan ? ST_CONV : ST_DELAY;
      cnt_next = 9'd0;
    end
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg <= `APFC_MODE_RST;
      chanReg <= `APFC_CHAN_RST;
      pfModeReg <= `APFC_PFM_RST;
      threshReg <= `APFC_PFT_RST;
      irqMaskReg <= `APFC_MASK_RST;
      irqStatReg <= 8'h00;
      resultReg <= 16'h0000;
      state_reg <= ST_IDLE;
      cnt_reg <= 9'h000;
      sar_reg <= 10'h200;
      bitIdx_reg <= 4'h0;
      firstAfterChan_reg <= 1'b0;
      pendValid_reg <= 1'b0;
      pendResult_reg <= 16'h0000;
      pendIrq_reg <= 1'b0;
      regRdata <= 16'h0000;
      channelSel <= 2'h0;
      sampleClose <= 1'b0;
      comparatorPower <= 1'b0;
      refStringOn <= 1'b0;
      sarTrial <= 10'h000;
      conversionBusy <= 1'b0;
      conversionEndIrq <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (regWr) begin
        case (regAddr)
          `APFC_ADDR_MODE: modeReg <= regWdata;
          `APFC_ADDR_CHAN: chanReg <= {6'h00, regWdata[1:0]};
          `APFC_ADDR_PFMODE: pfModeReg <= {regWdata[7:6], 6'h00};
          `APFC_ADDR_THRESH: threshReg <= regWdata;
          `APFC_ADDR_IRQMASK: irqMaskReg <= {6'h00, regWdata[1:0]};
          default: ;
        endcase
      end
      if (wrChan) begin
        firstAfterChan_reg <= 1'b1;
      end else if (convDone) begin
        firstAfterChan_reg <= 1'b0;
      end
      // Successive approximation sequence, restarted with each conversion
      if (state_next != ST_CONV || cnt_next == 9'd0) begin
        sar_reg <= 10'h200;
        bitIdx_reg <= 4'h0;
      end else if (bitTick) begin
        sar_reg <= (bitIdx_reg == 4'd9) ? sarDone : (sarDone | (curBit >> 1));
        bitIdx_reg <= bitIdx_reg + 4'd1;
      end
      // Result write: held one cycle when a result read collides
      pendValid_reg <= 1'b0;
      pendIrq_reg <= 1'b0;
      if (pendValid_reg) begin
        resultReg <= pendResult_reg;
      end
      if (convDone && !(wrMode || wrChan)) begin
        if (rdResult) begin
          pendValid_reg <= 1'b1;
          pendResult_reg <= newResult;
        end else begin
          resultReg <= newResult;
        end
      end
      // Status: set wins over write-one-to-clear
      begin : irqStatus
        reg [7:0] setBits;
        setBits = 8'h00;
        setBits[`APFC_IRQ_END] = convDone & ~(wrMode | wrChan) & endIrq;
        setBits[`APFC_IRQ_RESTART] = ctrlWr & running & (state_reg != ST_IDLE);
        if (regWr && regAddr == `APFC_ADDR_IRQSTAT) begin
          irqStatReg <= (irqStatReg & ~regWdata) | setBits;
        end else begin
          irqStatReg <= irqStatReg | setBits;
        end
        conversionEndIrq <= setBits[`APFC_IRQ_END];
        irqOut <= |(((irqStatReg & ~(regWr && regAddr == `APFC_ADDR_IRQSTAT ? regWdata : 8'h00))
          | setBits) & irqMaskReg);
      end
      regRdata <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          `APFC_ADDR_MODE: regRdata <= {8'h00, modeReg};
          `APFC_ADDR_CHAN: regRdata <= {8'h00, chanReg};
          `APFC_ADDR_PFMODE: regRdata <= {8'h00, pfModeReg};
          `APFC_ADDR_THRESH: regRdata <= {8'h00, threshReg};
          `APFC_ADDR_RESULT: regRdata <= resultReg;
          `APFC_ADDR_IRQSTAT: regRdata <= {8'h00, irqStatReg};
          `APFC_ADDR_IRQMASK: regRdata <= {8'h00, irqMaskReg};
          `APFC_ADDR_STATUS: regRdata <= {12'h000, firstAfterChan_reg, standbyReq, state_reg};
          default: regRdata <= 16'h0000;
        endcase
      end
      channelSel <= chanReg[1:0];
      comparatorPower <= modeReg[`APFC_MODE_CPWR] & ~standbyReq;
      refStringOn <= running;
      sampleClose <= (state_next == ST_CONV) && (cnt_next < sampleCycles);
      sarTrial <= sar_reg;
      conversionBusy <= (state_next != ST_IDLE);
    end
  end
endmodule

// ---- verif/apfc_checker.sv ----
// Port assertions for the converter control
`timescale 1ns/1ps
`include "apfc_defs.vh"
module apfc_checker (
  input wire core_clk,
  input wire rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [15:0] regRdata,
  input wire standbyReq,
  input wire [1:0] channelSel,
  input wire sampleClose,
  input wire comparatorPower,
  input wire refStringOn,
  input wire conversionBusy,
  input wire conversionEndIrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  reg [5:0] closeCnt;
  wire ctlWr;
  assign ctlWr = regWr && (regAddr == `APFC_ADDR_MODE || regAddr == `APFC_ADDR_CHAN);
  // Longest sample phase is 288/6, so the counter never needs more
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      closeCnt <= 6'h00;
    else
      closeCnt <= sampleClose ? closeCnt + 6'h01 : 6'h00;
  end
  sequence s_quiet;
    !conversionEndIrq [*8];
  endsequence
  property p_chan;
    regWr && regAddr == `APFC_ADDR_CHAN |-> ##2 channelSel == $past(regWdata[1:0], 2);
  endproperty
  property p_noend;
    ctlWr |=> s_quiet;
  endproperty
  property p_pulse;
    conversionEndIrq |=> !conversionEndIrq;
  endproperty
  property p_stby;
    standbyReq |=> !comparatorPower && !refStringOn;
  endproperty
  property p_samp;
    sampleClose |-> conversionBusy;
  endproperty
  property p_sampLen;
    closeCnt <= 6'h30;
  endproperty
  property p_rdIdle;
    !regRd |=> regRdata == 16'h0000;
  endproperty
  property p_pwrOff;
    regWr && regAddr == `APFC_ADDR_MODE && !regWdata[0] |-> ##[1:2] !comparatorPower;
  endproperty
  a_chan: assert property (p_chan) else $error("channel select not taken");
  a_noend: assert property (p_noend) else $error("end event after control write");
  a_pulse: assert property (p_pulse) else $error("end pulse too long");
  a_stby: assert property (p_stby) else $error("converter active in standby");
  a_samp: assert property (p_samp) else $error("sampling while idle");
  a_sampLen: assert property (p_sampLen) else $error("sample phase too long");
  a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
  a_pwrOff: assert property (p_pwrOff) else $error("comparator power stuck");
endmodule
bind apfc_adc_control apfc_checker u_chk (.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .standbyReq, .channelSel, .sampleClose, .comparatorPower, .refStringOn, .conversionBusy,
  .conversionEndIrq);

// ---- verif/apfc_adc_control_tb_top.sv ----
// Self-checking bench for the converter control
`timescale 1ns/1ps
`include "apfc_defs.vh"
module apfc_adc_control_tb_top;
  reg core_clk, rst_n, regWr, regRd, standbyReq, compareHigh;
  reg [2:0] regAddr;
  reg [7:0] regWdata;
  wire [15:0] regRdata;
  wire [1:0] channelSel;
  wire [9:0] sarTrial;
  wire sampleClose, comparatorPower, refStringOn, conversionBusy, conversionEndIrq, irqOut;
  reg [15:0] rv;
  reg [17:0] pfTab [0:3];
  integer failures, n_checks, i, k;
  apfc_adc_control DUT (.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .standbyReq,
    .compareHigh, .channelSel, .sampleClose, .comparatorPower, .refStringOn, .sarTrial, .conversionBusy,
    .conversionEndIrq, .irqOut);
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [15:0] d);
    begin
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
    end
  endtask
  // Bounded wait for the end pulse; n counts cycles waited
  task waitEnd(input integer lim, output integer n);
    begin
      n = 0;
      while (n < lim && conversionEndIrq !== 1'b1) begin
        @(posedge core_clk);
        #1 n = n + 1;
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    failures = failures + 1;
    close_out;
  end
  ////////////////////////////////////////
  initial begin
    failures = 0;
    n_checks = 0;
    {rst_n, regWr, regRd, standbyReq, compareHigh, regAddr, regWdata} = 15'h0000;
    // Entries: fire, comparator level, power-fail mode, threshold
    pfTab[0] = 18'h380FF;
    pfTab[1] = 18'h1C0FF;
    pfTab[2] = 18'h2C0FF;
    pfTab[3] = 18'h08001;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    compareHigh <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      rd(i[2:0], rv);
      if (i < 4 || i == 6) chk("reset value", 16'h0000, rv);
    end
    wr(`APFC_ADDR_MODE, 8'h31);
    repeat (560) @(posedge core_clk);
    chk("power", 16'h0001, {15'h0000, comparatorPower});
    wr(`APFC_ADDR_IRQMASK, 8'h01);
    wr(`APFC_ADDR_MODE, 8'hB1);
    waitEnd(400, k);
    chk("end", 16'h0003, {14'h0000, refStringOn, conversionEndIrq});
    rd(`APFC_ADDR_RESULT, rv);
    chk("result", 16'hFFC0, rv);
    rd(`APFC_ADDR_IRQSTAT, rv);
    chk("irq", 16'h0003, {rv[0], irqOut});
    wr(`APFC_ADDR_RESULT, 8'h00);
    rd(`APFC_ADDR_RESULT, rv);
    chk("result ro", 16'hFFC0, rv);
    wr(`APFC_ADDR_CHAN, 8'h03);
    rd(`APFC_ADDR_IRQSTAT, rv);
    chk("flag kept", 16'h0001, rv & 16'h0001);
    chk("channel", 16'h0003, {14'h0000, channelSel});
    waitEnd(400, k);
    chk("chan delay", 16'd96, 16'(k + 2));
    wr(`APFC_ADDR_IRQSTAT, 8'h03);
    rd(`APFC_ADDR_IRQSTAT, rv);
    chk("flag clear", 16'h0000, {rv[0], irqOut});
    for (i = 0; i < 4; i = i + 1) begin
      compareHigh <= pfTab[i][16];
      wr(`APFC_ADDR_THRESH, pfTab[i][7:0]);
      wr(`APFC_ADDR_PFMODE, pfTab[i][15:8]);
      waitEnd(300, k);
      chk("pf fire", {15'h0000, pfTab[i][17]}, {15'h0000, conversionEndIrq});
    end
    standbyReq <= 1'b1;
    waitEnd(300, k);
    chk("standby", 16'h0000, {13'h0000, conversionEndIrq, refStringOn, comparatorPower});
    standbyReq <= 1'b0;
    wr(`APFC_ADDR_MODE, 8'h31);
    repeat (2) @(posedge core_clk);
    chk("run off", 16'h0001, {14'h0000, refStringOn, comparatorPower});
    wr(`APFC_ADDR_MODE, 8'h00);
    repeat (2) @(posedge core_clk);
    chk("power off", 16'h0000, {14'h0000, refStringOn, comparatorPower});
    close_out;
  end
endmodule
